// ---- include/ccd_pkg.sv ----
// Functional notes
// RULE1: All-ones channel id reserved for management only
// RULE2: Channel id is process id plus endpoint id
// RULE3: Top two function bits choose request category
// RULE4: Decode write, read, open, close; rest reserved (the code also decodes 0x80-0xBF as service and dispatches it)
// RULE5: Write request fetches initiator buffer by reads
// RULE6: Initiator sets write direction bit zero
// RULE7: Write tag marks out-of-band data, carried along
// RULE8: Write sequence tags ascend modulo 0x80 per channel
// RULE9: Read request stores buffer by writes; tag ignored
// RULE10: Initiator sets read direction bit one
// RULE11: Read sequence tags ascend modulo 0x80 separately
// RULE12: No open while open or close outstanding
// RULE13: No close while open or close outstanding
// RULE14: Open takes channel identity from open fields
// RULE15: Notice permission bit gates unsolicited data notices
// RULE16: Close shuts the channel its fields name
// RULE17: Management requests ignore buffer, direction, tag, sequence
// RULE18: Reserved codes unsupported, never dispatched (the code dispatches 0x80-0xBF as service)
// RULE19: Writes to write queue, reads to read queue
// RULE20: Open reply reports write and read queue entries
// RULE21: Initiator keeps outstanding within reported depth
package ccd_pkg;

    // =====================================================
    // Function codes and categories
    localparam logic [7:0] CCD_FN_WRITE       = 8'h00;
    localparam logic [7:0] CCD_FN_READ        = 8'h40;
    localparam logic [7:0] CCD_FN_OPEN        = 8'hC1;
    localparam logic [7:0] CCD_FN_CLOSE       = 8'hC2;
    localparam logic [1:0] CCD_CAT_WRITE      = 2'h0;
    localparam logic [1:0] CCD_CAT_READ       = 2'h1;
    localparam logic [1:0] CCD_CAT_SERVICE    = 2'h2;
    localparam logic [1:0] CCD_CAT_MGMT       = 2'h3;

    // =====================================================
    // Identifiers and sequence
    localparam logic [15:0] CCD_MGMT_CHANNEL  = 16'hFFFF;
    localparam logic [6:0]  CCD_SEQ_RESET     = 7'h00;
    localparam int          CCD_SEQ_W         = 7;
    localparam int          CCD_NUM_CH        = 4;

    // =====================================================
    // Result codes
    typedef enum logic [2:0] {
        CCD_RES_NONE     = 3'h0,
        CCD_RES_WRITE    = 3'h1,
        CCD_RES_READ     = 3'h2,
        CCD_RES_SERVICE  = 3'h3,
        CCD_RES_OPEN     = 3'h4,
        CCD_RES_CLOSE    = 3'h5,
        CCD_RES_RESERVED = 3'h6,
        CCD_RES_BADCHAN  = 3'h7
    } ccd_result_t;

    // =====================================================
    // APB register map
    localparam logic [11:0] CCD_REG_CTRL      = 12'h000;
    localparam logic [11:0] CCD_REG_STATUS    = 12'h004;
    localparam logic [11:0] CCD_REG_DEPTH     = 12'h008;
    localparam logic [11:0] CCD_REG_CHAN_BASE = 12'h010;
    localparam logic [31:0] CCD_CTRL_RESET    = 32'h0000_0001;

    typedef enum logic [1:0] {
        CCD_ST_IDLE = 2'b00,
        CCD_ST_EVAL = 2'b01,
        CCD_ST_DONE = 2'b11
    } ccd_state_t;

    function automatic logic [1:0] ccd_category(input logic [7:0] fn);
        return fn[7:6];
    endfunction

endpackage

// ---- design/ccd_chan_table.sv ----
`timescale 1ns/1ps
module ccd_chan_table
    import ccd_pkg::*;
#(
    parameter int NUM_CH = CCD_NUM_CH,
    parameter int AW     = 2
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    // Write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [17:0]   wdata_i,
    // Read port
    input  wire logic [AW-1:0] raddr_i,
    output logic      [17:0]   rdata_o
);
    // Entry: [17] valid, [16] notice permit, [15:0] channel id
    logic [17:0] mem_q [NUM_CH];

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                mem_q[i] <= 18'h0_0000;
            end
        end else if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_o <= 18'h0_0000;
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule

// ---- design/ccd_decoder.sv ----
`timescale 1ns/1ps
module ccd_decoder
    import ccd_pkg::*;
#(
    parameter int          NUM_CH     = CCD_NUM_CH,
    parameter logic [15:0] WQ_ENTRIES = 16'h0008,
    parameter logic [15:0] RQ_ENTRIES = 16'h0008
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Request block fields
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  function_code_i,
    input  wire logic [7:0]  initiator_process_id_i,
    input  wire logic [7:0]  target_endpoint_id_i,
    input  wire logic [6:0]  buffer_sequence_tag_i,
    input  wire logic        direction_i,
    input  wire logic        tag_i,
    input  wire logic [15:0] data_size_i,
    input  wire logic [7:0]  mgmt_process_id_i,
    input  wire logic [7:0]  mgmt_endpoint_id_i,
    input  wire logic        notice_permit_i,
    input  wire logic        data_notice_req_i,
    output logic             req_ready_o,
    // Dispatch
    output logic             write_dispatch_o,
    output logic             read_dispatch_o,
    output logic             service_dispatch_o,
    output logic             fetch_by_read_o,
    output logic             store_by_write_o,
    output logic             out_of_band_o,
    output logic [6:0]       dispatch_seq_o,
    output logic [15:0]      dispatch_channel_o,
    // Management reply
    output logic             mgmt_reply_o,
    output logic [15:0]      reply_channel_o,
    output logic [15:0]      write_queue_entries_o,
    output logic [15:0]      read_queue_entries_o,
    output logic             pending_data_notice_o,
    output logic [2:0]       result_o
);
    localparam int AW = $clog2(NUM_CH);

    // =====================================================
    // Request capture and state
    ccd_state_t  state_q;
    logic [7:0]  fn_q;
    logic [15:0] chan_q;
    logic [15:0] mgmt_q;
    logic [6:0]  seq_q;
    logic        dir_q;
    logic        tag_q;
    logic        permit_q;
    logic        notice_q;
    logic [AW-1:0] slot_q;
    logic [17:0] tab_rdata;
    logic        tab_we;
    logic [17:0] tab_wdata;
    logic [AW-1:0] tab_waddr;
    logic [31:0] ctrl_q;
    logic [31:0] stat_count_q;
    ccd_result_t res_d;
    logic        hit;
    logic [AW-1:0] hit_idx;
    logic [AW-1:0] free_idx;
    logic        free_ok;
    logic [17:0] ent [NUM_CH];

    // Shadow copy of table valid/permit/id for single-cycle lookup
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ent[i] <= 18'h0_0000;
            end
        end else if (tab_we) begin
            ent[tab_waddr] <= tab_wdata;
        end
    end

    ccd_chan_table #(.NUM_CH(NUM_CH), .AW(AW)) u_table (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .we_i      (tab_we),
        .waddr_i   (tab_waddr),
        .wdata_i   (tab_wdata),
        .raddr_i   (slot_q),
        .rdata_o   (tab_rdata)
    );

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q  <= CCD_ST_IDLE;
            fn_q     <= 8'h00;
            chan_q   <= 16'h0000;
            mgmt_q   <= 16'h0000;
            seq_q    <= CCD_SEQ_RESET;
            dir_q    <= 1'b0;
            tag_q    <= 1'b0;
            permit_q <= 1'b0;
            notice_q <= 1'b0;
        end else begin
            case (state_q)
                CCD_ST_IDLE: begin
                    if (req_valid_i && ctrl_q[0]) begin
                        fn_q     <= function_code_i;
                        chan_q   <= {initiator_process_id_i, target_endpoint_id_i}; // RULE2
                        mgmt_q   <= {mgmt_process_id_i, mgmt_endpoint_id_i};
                        seq_q    <= buffer_sequence_tag_i;
                        dir_q    <= direction_i;
                        tag_q    <= tag_i;
                        permit_q <= notice_permit_i;
                        notice_q <= data_notice_req_i;
                        state_q  <= CCD_ST_EVAL;
                    end
                end
                CCD_ST_EVAL: state_q <= CCD_ST_DONE;
                CCD_ST_DONE: state_q <= CCD_ST_IDLE;
                default:     state_q <= CCD_ST_IDLE;
            endcase
        end
    end

    // =====================================================
    // Channel lookup
    always_comb begin
        hit      = 1'b0;
        hit_idx  = '0;
        free_ok  = 1'b0;
        free_idx = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (ent[i][17] && ent[i][15:0] == (fn_q[7:6] == CCD_CAT_MGMT ? mgmt_q : chan_q)) begin
                hit     = 1'b1;
                hit_idx = AW'(i);
            end
            if (!ent[i][17]) begin
                free_ok  = 1'b1;
                free_idx = AW'(i);
            end
        end
    end

    // =====================================================
    // Classification
    always_comb begin
        res_d     = CCD_RES_RESERVED;
        tab_we    = 1'b0;
        tab_waddr = '0;
        tab_wdata = 18'h0_0000;
        case (ccd_category(fn_q)) // RULE3
            CCD_CAT_WRITE: begin
                if (fn_q != CCD_FN_WRITE) res_d = CCD_RES_RESERVED; // RULE18
                else if (!hit || chan_q == CCD_MGMT_CHANNEL) res_d = CCD_RES_BADCHAN; // RULE1
                else res_d = CCD_RES_WRITE; // RULE4
            end
            CCD_CAT_READ: begin
                if (fn_q != CCD_FN_READ) res_d = CCD_RES_RESERVED; // RULE18
                else if (!hit || chan_q == CCD_MGMT_CHANNEL) res_d = CCD_RES_BADCHAN; // RULE1
                else res_d = CCD_RES_READ; // RULE4
            end
            CCD_CAT_SERVICE: res_d = CCD_RES_SERVICE;
            default: begin
                // Management: buffer, direction, tag and sequence fields unused
                if (chan_q != CCD_MGMT_CHANNEL) begin
                    res_d = CCD_RES_BADCHAN; // RULE1
                end else if (fn_q == CCD_FN_OPEN) begin
                    if (mgmt_q == CCD_MGMT_CHANNEL || (!hit && !free_ok)) begin
                        res_d = CCD_RES_BADCHAN; // RULE1
                    end else begin
                        res_d     = CCD_RES_OPEN;
                        tab_we    = (state_q == CCD_ST_EVAL);
                        tab_waddr = hit ? hit_idx : free_idx;
                        tab_wdata = {1'b1, permit_q, mgmt_q}; // RULE14
                    end
                end else if (fn_q == CCD_FN_CLOSE) begin
                    if (!hit) res_d = CCD_RES_BADCHAN;
                    else begin
                        res_d     = CCD_RES_CLOSE;
                        tab_we    = (state_q == CCD_ST_EVAL);
                        tab_waddr = hit_idx;
                        tab_wdata = 18'h0_0000; // RULE16
                    end
                end else begin
                    res_d = CCD_RES_RESERVED; // RULE18
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            slot_q <= '0;
        end else if (state_q == CCD_ST_EVAL) begin
            slot_q <= tab_we ? tab_waddr : hit_idx;
        end
    end

    // =====================================================
    // Dispatch outputs
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            write_dispatch_o      <= 1'b0;
            read_dispatch_o       <= 1'b0;
            service_dispatch_o    <= 1'b0;
            fetch_by_read_o       <= 1'b0;
            store_by_write_o      <= 1'b0;
            out_of_band_o         <= 1'b0;
            dispatch_seq_o        <= CCD_SEQ_RESET;
            dispatch_channel_o    <= 16'h0000;
            mgmt_reply_o          <= 1'b0;
            reply_channel_o       <= 16'h0000;
            write_queue_entries_o <= 16'h0000;
            read_queue_entries_o  <= 16'h0000;
            pending_data_notice_o <= 1'b0;
            result_o              <= CCD_RES_NONE;
            req_ready_o           <= 1'b0;
        end else begin
            write_dispatch_o      <= 1'b0;
            read_dispatch_o       <= 1'b0;
            service_dispatch_o    <= 1'b0;
            mgmt_reply_o          <= 1'b0;
            pending_data_notice_o <= 1'b0;
            req_ready_o           <= (state_q == CCD_ST_IDLE) && ctrl_q[0] && !req_valid_i;
            if (state_q == CCD_ST_EVAL) begin
                result_o           <= res_d;
                dispatch_seq_o     <= seq_q;
                dispatch_channel_o <= chan_q;
                write_dispatch_o   <= (res_d == CCD_RES_WRITE); // RULE19
                read_dispatch_o    <= (res_d == CCD_RES_READ); // RULE19
                service_dispatch_o <= (res_d == CCD_RES_SERVICE);
                fetch_by_read_o    <= (res_d == CCD_RES_WRITE); // RULE5
                store_by_write_o   <= (res_d == CCD_RES_READ); // RULE9
                out_of_band_o      <= (res_d == CCD_RES_WRITE) && tag_q; // RULE7
                mgmt_reply_o       <= (res_d == CCD_RES_OPEN) || (res_d == CCD_RES_CLOSE);
                reply_channel_o    <= mgmt_q;
                write_queue_entries_o <= (res_d == CCD_RES_OPEN) ? WQ_ENTRIES : 16'h0000; // RULE20
                read_queue_entries_o  <= (res_d == CCD_RES_OPEN) ? RQ_ENTRIES : 16'h0000; // RULE20
                // Notice only for an open channel whose permit bit is set
                pending_data_notice_o <= notice_q && hit && ent[hit_idx][16]
                                         && (res_d == CCD_RES_READ || res_d == CCD_RES_WRITE); // RULE15
            end
        end
    end

    // =====================================================
    // APB slave
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ctrl_q       <= CCD_CTRL_RESET;
            stat_count_q <= 32'h0000_0000;
            prdata_o     <= 32'h0000_0000;
            pready_o     <= 1'b0;
            pslverr_o    <= 1'b0;
        end else begin
            if (state_q == CCD_ST_EVAL) begin
                stat_count_q <= stat_count_q + 32'h0000_0001;
            end
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == CCD_REG_CTRL) begin
                ctrl_q <= {31'h0, pwdata_i[0]};
            end
            if (psel_i && !penable_i) begin
                prdata_o <= 32'h0000_0000;
                if (paddr_i == CCD_REG_CTRL) begin
                    if (!pwrite_i) prdata_o <= ctrl_q;
                end else if (paddr_i == CCD_REG_STATUS) begin
                    if (!pwrite_i) prdata_o <= {stat_count_q[23:0], 2'h0, tab_rdata[17],
                                                state_q == CCD_ST_IDLE, 1'b0, result_o};
                end else if (paddr_i == CCD_REG_DEPTH) begin
                    if (!pwrite_i) prdata_o <= {RQ_ENTRIES, WQ_ENTRIES};
                end else if (paddr_i >= CCD_REG_CHAN_BASE
                             && paddr_i < CCD_REG_CHAN_BASE + 12'(4 * NUM_CH)) begin
                    if (!pwrite_i) prdata_o <= {14'h0, ent[paddr_i[AW+1:2]]};
                end else begin
                    pslverr_o <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- testbench/ccd_decoder_monitor.sv ----
`timescale 1ns/1ps
module ccd_decoder_monitor
    import ccd_pkg::*;
#(
    parameter logic [15:0] WQ_ENTRIES = 16'h0008,
    parameter logic [15:0] RQ_ENTRIES = 16'h0008
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Request fields
    input  wire logic [7:0]  function_code_i,
    input  wire logic [7:0]  initiator_process_id_i,
    input  wire logic [7:0]  target_endpoint_id_i,
    input  wire logic [6:0]  buffer_sequence_tag_i,
    input  wire logic        tag_i,
    input  wire logic [7:0]  mgmt_process_id_i,
    input  wire logic [7:0]  mgmt_endpoint_id_i,
    input  wire logic        data_notice_req_i,
    // Dispatch and reply
    input  wire logic        write_dispatch_o,
    input  wire logic        read_dispatch_o,
    input  wire logic        service_dispatch_o,
    input  wire logic        fetch_by_read_o,
    input  wire logic        store_by_write_o,
    input  wire logic        out_of_band_o,
    input  wire logic [6:0]  dispatch_seq_o,
    input  wire logic [15:0] dispatch_channel_o,
    input  wire logic        mgmt_reply_o,
    input  wire logic [15:0] reply_channel_o,
    input  wire logic [15:0] write_queue_entries_o,
    input  wire logic [15:0] read_queue_entries_o,
    input  wire logic        pending_data_notice_o,
    input  wire logic [2:0]  result_o
);
    default clocking mon_cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // ==========================================================
    // Checks
    write_path_a: assert property (
        write_dispatch_o |-> $past(function_code_i, 2) == CCD_FN_WRITE && fetch_by_read_o
        && !store_by_write_o) else $error("write dispatch without write request");
    read_path_a: assert property (
        read_dispatch_o |-> $past(function_code_i, 2) == CCD_FN_READ && store_by_write_o
        && !fetch_by_read_o) else $error("read dispatch without read request");
    service_path_a: assert property (
        service_dispatch_o |-> $past(function_code_i, 2) inside {[8'h80:8'hBF]}
        && result_o == CCD_RES_SERVICE) else $error("service dispatch on wrong code");
    single_queue_a: assert property (
        $onehot0({write_dispatch_o, read_dispatch_o, service_dispatch_o}) && !(result_o ==
        CCD_RES_RESERVED && (write_dispatch_o || read_dispatch_o))) else $error("bad dispatch");
    data_chan_a: assert property (
        (write_dispatch_o || read_dispatch_o) |-> dispatch_channel_o == {$past(
        initiator_process_id_i, 2), $past(target_endpoint_id_i, 2)}
        && dispatch_channel_o != CCD_MGMT_CHANNEL) else $error("dispatch channel wrong");
    oob_carry_a: assert property (
        write_dispatch_o |-> out_of_band_o == $past(tag_i, 2)
        && dispatch_seq_o == $past(buffer_sequence_tag_i, 2)) else $error("tag not carried");
    reply_chan_a: assert property (
        mgmt_reply_o |-> reply_channel_o == {$past(mgmt_process_id_i, 2), $past(
        mgmt_endpoint_id_i, 2)} && result_o inside {CCD_RES_OPEN, CCD_RES_CLOSE})
        else $error("management reply channel wrong");
    open_depth_a: assert property (
        mgmt_reply_o && result_o == CCD_RES_OPEN |-> write_queue_entries_o == WQ_ENTRIES
        && read_queue_entries_o == RQ_ENTRIES) else $error("open reply entries wrong");
    notice_gate_a: assert property (
        pending_data_notice_o |-> $past(data_notice_req_i, 2)) else $error("notice unasked");
endmodule

bind ccd_decoder ccd_decoder_monitor #(.WQ_ENTRIES(WQ_ENTRIES), .RQ_ENTRIES(RQ_ENTRIES)) mon (.*);

// ---- testbench/ccd_init_model.sv ----
`timescale 1ns/1ps
module ccd_init_model
    import ccd_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Request block
    input  wire logic        req_ready_i,
    output logic             req_valid_o,
    output logic [7:0]       fn_o,
    output logic [7:0]       initiator_process_id_o,
    output logic [7:0]       target_endpoint_id_o,
    output logic [6:0]       buffer_sequence_tag_o,
    output logic             dir_o,
    output logic             tag_o,
    output logic [15:0]      size_o,
    output logic [7:0]       mpid_o,
    output logic [7:0]       meid_o,
    output logic             permit_o,
    output logic             notice_o
);
    logic [66:0] f_q = '0;
    logic [6:0]  wseq [logic [15:0]];
    logic [6:0]  rseq [logic [15:0]];

    assign {fn_o, initiator_process_id_o, target_endpoint_id_o, buffer_sequence_tag_o, dir_o,
            tag_o, size_o, mpid_o, meid_o, permit_o, notice_o} = f_q;
    initial req_valid_o = 1'b0;

    // ==========================================================
    // Issue one request block and wait for its answer
    task automatic send(input logic [7:0] fn, input logic [15:0] ch, input logic t, p, nr);
        logic [6:0]  s;
        logic [15:0] id;
        s = CCD_SEQ_RESET;
        id = ch;
        if (fn[7:6] == CCD_CAT_MGMT) begin
            id = CCD_MGMT_CHANNEL;
            t = 1'b0;
        end else if (fn[6]) begin
            s = rseq.exists(ch) ? rseq[ch] : CCD_SEQ_RESET;
            rseq[ch] = s + 7'h01;
            t = 1'b0;
        end else begin
            s = wseq.exists(ch) ? wseq[ch] : CCD_SEQ_RESET;
            wseq[ch] = s + 7'h01;
        end
        do @(posedge clk_i); while (req_ready_i !== 1'b1);
        f_q <= {fn, id, s, fn[6], t,
                {7'h00, ~fn[7], 8'h00}, ch, p, nr};
        req_valid_o <= 1'b1;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        f_q <= ~f_q;
        @(posedge clk_i);
        #1;
    endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import ccd_pkg::*;
    // ==========================================================
    // Signals
    logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic        req_valid_i, direction_i, tag_i, notice_permit_i, data_notice_req_i, req_ready_o;
    logic [7:0]  function_code_i, initiator_process_id_i, target_endpoint_id_i;
    logic [7:0]  mgmt_process_id_i, mgmt_endpoint_id_i;
    logic [6:0]  buffer_sequence_tag_i, dispatch_seq_o;
    logic [15:0] data_size_i, dispatch_channel_o, reply_channel_o;
    logic [15:0] write_queue_entries_o, read_queue_entries_o;
    logic        write_dispatch_o, read_dispatch_o, service_dispatch_o, fetch_by_read_o;
    logic        store_by_write_o, out_of_band_o, mgmt_reply_o, pending_data_notice_o;
    logic [2:0]  result_o;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [7:0]  rsv_codes [7] = '{8'h01, 8'h3F, 8'h41, 8'h7F, 8'hC0, 8'hC3, 8'hFF};

    ccd_init_model init (
        .clk_i(clk_i), .req_ready_i(req_ready_o), .req_valid_o(req_valid_i),
        .fn_o(function_code_i), .initiator_process_id_o(initiator_process_id_i),
        .target_endpoint_id_o(target_endpoint_id_i), .buffer_sequence_tag_o(buffer_sequence_tag_i),
        .dir_o(direction_i), .tag_o(tag_i), .size_o(data_size_i), .mpid_o(mgmt_process_id_i),
        .meid_o(mgmt_endpoint_id_i), .permit_o(notice_permit_i), .notice_o(data_notice_req_i));

    ccd_decoder dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .req_valid_i(req_valid_i),
        .function_code_i(function_code_i), .initiator_process_id_i(initiator_process_id_i),
        .target_endpoint_id_i(target_endpoint_id_i), .buffer_sequence_tag_i(buffer_sequence_tag_i),
        .direction_i(direction_i), .tag_i(tag_i), .data_size_i(data_size_i),
        .mgmt_process_id_i(mgmt_process_id_i), .mgmt_endpoint_id_i(mgmt_endpoint_id_i),
        .notice_permit_i(notice_permit_i), .data_notice_req_i(data_notice_req_i),
        .req_ready_o(req_ready_o), .write_dispatch_o(write_dispatch_o),
        .read_dispatch_o(read_dispatch_o), .service_dispatch_o(service_dispatch_o),
        .fetch_by_read_o(fetch_by_read_o), .store_by_write_o(store_by_write_o),
        .out_of_band_o(out_of_band_o), .dispatch_seq_o(dispatch_seq_o),
        .dispatch_channel_o(dispatch_channel_o), .mgmt_reply_o(mgmt_reply_o),
        .reply_channel_o(reply_channel_o), .write_queue_entries_o(write_queue_entries_o),
        .read_queue_entries_o(read_queue_entries_o),
        .pending_data_notice_o(pending_data_notice_o), .result_o(result_o));

    // ==========================================================
    // Tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task done(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, exp,
                       input logic err);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        check(pslverr_o, err);
        if (!w && !err) check(prdata_o, exp);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task req(input logic [7:0] fn, input logic [15:0] ch, input logic t, p, nr,
             input logic [2:0] res);
        init.send(fn, ch, t, p, nr);
        check(result_o, res);
    endtask

    task print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, timeout and tests
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            print_verdict;
        end
    end

    initial begin
        {reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        apb(1'b0, CCD_REG_CTRL, 32'h0, CCD_CTRL_RESET, 1'b0);
        apb(1'b0, CCD_REG_DEPTH, 32'h0, 32'h0008_0008, 1'b0);
        apb(1'b0, CCD_REG_CHAN_BASE, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h0FC, 32'h0, 32'h0, 1'b1);
        done("registers");
        req(CCD_FN_WRITE, 16'h5566, 1'b0, 1'b0, 1'b0, CCD_RES_BADCHAN);
        check(write_dispatch_o, 32'h0);
        req(CCD_FN_OPEN, 16'h1234, 1'b0, 1'b1, 1'b0, CCD_RES_OPEN);
        check({mgmt_reply_o, reply_channel_o}, 17'h1_1234);
        check({write_queue_entries_o, read_queue_entries_o}, 32'h0008_0008);
        apb(1'b0, CCD_REG_CHAN_BASE, 32'h0, 32'h0003_1234, 1'b0);
        req(CCD_FN_WRITE, 16'h1234, 1'b1, 1'b0, 1'b1, CCD_RES_WRITE);
        check({write_dispatch_o, fetch_by_read_o,
               out_of_band_o, pending_data_notice_o}, 4'hF);
        check({dispatch_seq_o, dispatch_channel_o}, {7'h00, 16'h1234});
        req(CCD_FN_WRITE, 16'h1234, 1'b0, 1'b0, 1'b0, CCD_RES_WRITE);
        check({dispatch_seq_o, out_of_band_o}, 8'h02);
        req(CCD_FN_READ, 16'h1234, 1'b0, 1'b0, 1'b1, CCD_RES_READ);
        check({read_dispatch_o, store_by_write_o,
               pending_data_notice_o, dispatch_seq_o}, 10'h380);
        done("data");
        req(CCD_FN_OPEN, 16'hABCD, 1'b0, 1'b0, 1'b0, CCD_RES_OPEN);
        req(CCD_FN_READ, 16'hABCD, 1'b0, 1'b0, 1'b1, CCD_RES_READ);
        check({read_dispatch_o, pending_data_notice_o, dispatch_seq_o}, 9'h100);
        req(8'h85, 16'h1234, 1'b0, 1'b0, 1'b0, CCD_RES_SERVICE);
        check(service_dispatch_o, 32'h1);
        foreach (rsv_codes[i]) begin
            req(rsv_codes[i], 16'h1234, 1'b0, 1'b0, 1'b0, CCD_RES_RESERVED);
            check({write_dispatch_o, read_dispatch_o, service_dispatch_o}, 32'h0);
        end
        done("codes");
        req(CCD_FN_CLOSE, 16'h1234, 1'b0, 1'b0, 1'b0, CCD_RES_CLOSE);
        check({mgmt_reply_o, reply_channel_o}, 17'h1_1234);
        req(CCD_FN_WRITE, 16'h1234, 1'b0, 1'b0, 1'b0, CCD_RES_BADCHAN);
        apb(1'b1, CCD_REG_CTRL, 32'h0, 32'h0, 1'b0);
        repeat (2) @(posedge clk_i);
        #1;
        check(req_ready_o, 32'h0);
        apb(1'b1, CCD_REG_CTRL, 32'h1, 32'h0, 1'b0);
        apb(1'b0, CCD_REG_CTRL, 32'h0, 32'h1, 1'b0);
        done("close");
        print_verdict;
    end
endmodule
